/* rtl/d4f_pkg.sv */
// Shared constants and types for the DDR4 command pin front end
package d4f_pkg;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {CMD_MRS, CMD_REF, CMD_PRE, CMD_WR, CMD_RD, CMD_ZQC, CMD_ACT,
                              CMD_SRE} d4f_cmd_t;
    typedef enum logic [1:0] {PWR_ON, PWR_PPD, PWR_APD, PWR_SR} d4f_pwr_t;
    // ----------------------------------------
    // Organisation
    // ----------------------------------------
    localparam int NUM_BG = 2;
    localparam int BANKS_PER_BG = 4;
    localparam int NUM_BANKS = NUM_BG * BANKS_PER_BG;
    localparam logic [3:0] BURST_FULL = 4'h8;
    localparam logic [3:0] BURST_CHOP = 4'h4;
    localparam int AP_BIT = 10;
    localparam int BC_BIT = 12;
    localparam int FIFO_DEPTH = 16;
    // ----------------------------------------
    // Row/column/write-enable encodings, activate high
    // ----------------------------------------
    localparam logic [2:0] ENC_MRS = 3'h0;
    localparam logic [2:0] ENC_REF = 3'h1;
    localparam logic [2:0] ENC_PRE = 3'h2;
    localparam logic [2:0] ENC_WR = 3'h4;
    localparam logic [2:0] ENC_RD = 3'h5;
    localparam logic [2:0] ENC_ZQC = 3'h6;
    // ----------------------------------------
    // Latency settings
    // ----------------------------------------
    localparam logic [1:0] AL_ZERO = 2'h0;
    localparam logic [1:0] AL_CL_M1 = 2'h1;
    localparam logic [1:0] AL_CL_M2 = 2'h2;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 40;
    localparam int PAR_RECOV_NS = 2000;
    localparam int PAR_RECOV_CYC = (PAR_RECOV_NS * CLK_MHZ) / 1000;
    localparam int CRC_PULSE_NS = 250;
    localparam int CRC_PULSE_CYC = (CRC_PULSE_NS * CLK_MHZ + 999) / 1000;
endpackage : d4f_pkg

/* rtl/d4f_fifo_if.sv */
// Valid/ready carrier between the front end and its write data FIFO
`timescale 1ns/10ps
interface d4f_fifo_if #(parameter int W = 18);
    logic [W-1:0] in_data;
    logic in_valid;
    logic in_ready;
    logic [W-1:0] out_data;
    logic out_valid;
    logic out_ready;
    modport fifo (input in_data, input in_valid, input out_ready,
                  output in_ready, output out_data, output out_valid);
    modport core (output in_data, output in_valid, output out_ready,
                  input in_ready, input out_data, input out_valid);
endinterface : d4f_fifo_if

/* rtl/d4f_fifo.sv */
// Write data FIFO with parameter width and depth
`timescale 1ns/10ps
module d4f_fifo #(
    parameter int W = 18,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Both sides
    d4f_fifo_if.fifo f
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    logic full;
    logic empty;

    assign empty = (wr_ptr_r == rd_ptr_r);
    assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign f.in_ready = !full;
    assign f.out_valid = !empty;
    assign f.out_data = mem[rd_ptr_r[AW-1:0]];

    always_ff @(posedge clk)
    begin
        if (f.in_valid && !full)
        begin
            mem[wr_ptr_r[AW-1:0]] <= f.in_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end
        else
        begin
            if (f.in_valid && !full)
            begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (f.out_ready && !empty)
            begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end
endmodule : d4f_fifo

/* rtl/d4f_front.sv */
// DDR4 x16 command, address and control pin front end
`timescale 1ns/10ps
//
// Contract
// - Sample command and address pins on the rising edge of the true clock.
// - Clock enable low enters precharge/active power-down by bank state, or self-refresh with a refresh command.
// - Power-down keeps clock, termination, clock enable buffers; self-refresh keeps clock enable.
// - Self-refresh exit detected from clock-sampled clock enable.
// - Commands with chip select high are ignored; chip select is part of the command.
// - Registered termination high applies nominal termination to data, strobes and masks.
// - Termination input ignored while nominal termination is disabled.
// - Activate low with select low decodes activate; shared pins become row bits 15,14.
// - Activate high makes row, column, write-enable pins a command code.
// - Byte mask sampled on both strobe edges; beats with both bytes masked are discarded.
// - Mode bits choose data mask or bus inversion function of the shared pin.
// - Inversion flag low means the byte is inverted, on writes and on reads.
// - Bank group input selects the bank group of activate, read, write, precharge.
// - Bank inputs select the bank; with bank group they select the mode register.
// - Eight banks in two groups of four.
// - Read latency of 9, 11 to 16 and 18 to 24 cycles.
// - Additive latency of zero, read latency minus one or minus two.
// - Burst of eight or chopped four, chosen per command.
// - Write latency of 9, 10, 11, 12, 14, 16, 18 or 20 cycles.
// - Address bit ten: auto-precharge on access, all banks on precharge.
// - Address bit twelve low chops the burst, high gives full burst.
// - Even parity over command, bank and address checked when enabled.
// - CRC error pulses alert low briefly; parity error holds it through recovery.
module d4f_front (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Link clock and command pins
    input wire logic ck_t,
    input wire logic ck_c,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic act_n,
    input wire logic ras_n,
    input wire logic cas_n_a15,
    input wire logic we_n_a14,
    input wire logic bg0,
    input wire logic [1:0] ba,
    input wire logic [13:0] addr,
    input wire logic odt,
    input wire logic par,
    // Data pins
    input wire logic [1:0] dqs_t,
    input wire logic [15:0] dq_i,
    input wire logic [1:0] dm_dbi_n_i,
    output logic [15:0] dq_o,
    output logic dq_oe_n,
    output logic [1:0] dbi_n_o,
    output logic alert_n_o,
    output logic alert_oe_n,
    // Mode settings
    input wire logic rtt_nom_en,
    input wire logic mr5_dm_en,
    input wire logic mr5_wdbi_en,
    input wire logic mr5_rdbi_en,
    input wire logic par_en,
    input wire logic [4:0] cl_sel,
    input wire logic [1:0] al_sel,
    input wire logic [4:0] cwl_sel,
    input wire logic crc_err,
    // Decoded command
    output logic cmd_valid,
    output d4f_pkg::d4f_cmd_t cmd,
    output logic cmd_bg,
    output logic [1:0] cmd_ba,
    output logic [15:0] cmd_row,
    output logic [9:0] cmd_col,
    output logic cmd_ap,
    output logic cmd_bc4,
    output logic [2:0] mrs_sel,
    output logic par_err,
    // Power and termination
    output d4f_pkg::d4f_pwr_t pwr_state,
    output logic ck_buf_en,
    output logic cmd_buf_en,
    output logic odt_buf_en,
    output logic rtt_nom_on,
    output logic [d4f_pkg::NUM_BANKS-1:0] bank_open,
    // Latency
    output logic lat_ok,
    output logic [5:0] read_lat,
    output logic [5:0] write_lat,
    // Write data out
    output logic [15:0] wr_data,
    output logic [1:0] wr_be,
    output logic wr_valid,
    input wire logic wr_ready,
    output logic wr_drop,
    // Read data in
    input wire logic [15:0] rd_data,
    input wire logic rd_valid
);
    localparam int SW = 47;
    logic [SW-1:0] sync1_r;
    logic [SW-1:0] sync2_r;
    logic ck_d_r;
    logic dqs_d_r;
    logic ck_s, ckc_s, cke_s, cs_s, act_s, ras_s, cas_s, we_s, bg_s, odt_s, par_s, dqs_s;
    logic [1:0] ba_s;
    logic [1:0] dm_s;
    logic [13:0] addr_s;
    logic [15:0] dq_s;
    logic ck_rise;
    logic dqs_edge;
    logic par_bad;
    logic cke_prev_r;
    logic [3:0] wr_left;
    logic push_r;
    logic [15:0] push_data_r;
    logic [1:0] push_be_r;
    logic [7:0] alert_cnt_r;
    logic odt_r;
    logic [2:0] enc;
    d4f_fifo_if #(.W(18)) fq ();

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic [2:0] bank_idx(input logic g, input logic [1:0] b);
        bank_idx = {g, b};
    endfunction : bank_idx

    function automatic logic ones_gt4(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++)
        begin
            n = n + {3'h0, v[i]};
        end
        ones_gt4 = (n > 4'h4);
    endfunction : ones_gt4

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            ck_d_r <= 1'b0;
            dqs_d_r <= 1'b0;
        end
        else
        begin
            sync1_r <= {ck_t, ck_c, cke, cs_n, act_n, ras_n, cas_n_a15, we_n_a14, bg0, ba,
                        addr, odt, par, dqs_t, dq_i, dm_dbi_n_i};
            sync2_r <= sync1_r;
            ck_d_r <= ck_s;
            dqs_d_r <= dqs_s;
        end
    end

    // Only lane 0 strobe is kept; lane 1 strobe bit is skipped on purpose
    assign {ck_s, ckc_s, cke_s, cs_s, act_s, ras_s, cas_s, we_s, bg_s, ba_s, addr_s, odt_s,
            par_s, dqs_s} = {sync2_r[SW-1:20], sync2_r[18]};
    assign dq_s = sync2_r[17:2];
    assign dm_s = sync2_r[1:0];
    // True rising while the complement is low is the crossing point
    assign ck_rise = ck_s && !ckc_s && !ck_d_r;
    // Lane 0 strobe clocks both lanes; skew between lanes is invisible at this rate
    assign dqs_edge = dqs_s ^ dqs_d_r;
    assign enc = {ras_s, cas_s, we_s};
    assign par_bad = par_en
                     && ^{act_s, ras_s, cas_s, we_s, bg_s, ba_s, addr_s, par_s};

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            cmd_valid <= 1'b0;
            cmd <= d4f_pkg::CMD_ZQC;
            cmd_bg <= 1'b0;
            cmd_ba <= 2'h0;
            cmd_row <= 16'h0000;
            cmd_col <= 10'h000;
            cmd_ap <= 1'b0;
            cmd_bc4 <= 1'b0;
            mrs_sel <= 3'h0;
            par_err <= 1'b0;
        end
        else
        begin
            cmd_valid <= 1'b0;
            par_err <= 1'b0;
            if (ck_rise && !cs_s && pwr_state == d4f_pkg::PWR_ON)
            begin
                cmd_bg <= bg_s;
                cmd_ba <= ba_s;
                mrs_sel <= bank_idx(bg_s, ba_s);
                cmd_row <= {cas_s, we_s, addr_s};
                cmd_col <= addr_s[9:0];
                cmd_ap <= addr_s[d4f_pkg::AP_BIT];
                cmd_bc4 <= !addr_s[d4f_pkg::BC_BIT];
                if (par_bad)
                begin
                    par_err <= 1'b1;
                end
                else if (cke_prev_r && !cke_s && act_s && enc == d4f_pkg::ENC_REF)
                begin
                    cmd_valid <= 1'b1;
                    cmd <= d4f_pkg::CMD_SRE;
                end
                else if (cke_prev_r && cke_s)
                begin
                    cmd_valid <= 1'b1;
                    if (!act_s)
                    begin
                        cmd <= d4f_pkg::CMD_ACT;
                    end
                    else
                    begin
                        unique case (enc)
                            d4f_pkg::ENC_MRS: cmd <= d4f_pkg::CMD_MRS;
                            d4f_pkg::ENC_REF: cmd <= d4f_pkg::CMD_REF;
                            d4f_pkg::ENC_PRE: cmd <= d4f_pkg::CMD_PRE;
                            d4f_pkg::ENC_WR: cmd <= d4f_pkg::CMD_WR;
                            d4f_pkg::ENC_RD: cmd <= d4f_pkg::CMD_RD;
                            d4f_pkg::ENC_ZQC: cmd <= d4f_pkg::CMD_ZQC;
                            default: cmd_valid <= 1'b0;
                        endcase
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // Bank state, eight banks in two groups
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            bank_open <= '0;
        end
        else if (cmd_valid)
        begin
            unique case (cmd)
                d4f_pkg::CMD_ACT: bank_open[bank_idx(cmd_bg, cmd_ba)] <= 1'b1;
                d4f_pkg::CMD_PRE:
                    if (cmd_ap)
                    begin
                        bank_open <= '0;
                    end
                    else
                    begin
                        bank_open[bank_idx(cmd_bg, cmd_ba)] <= 1'b0;
                    end
                d4f_pkg::CMD_RD, d4f_pkg::CMD_WR:
                    if (cmd_ap)
                    begin
                        bank_open[bank_idx(cmd_bg, cmd_ba)] <= 1'b0;
                    end
                default: bank_open <= bank_open;
            endcase
        end
    end

    // ----------------------------------------
    // Power state and input buffers
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            pwr_state <= d4f_pkg::PWR_ON;
            cke_prev_r <= 1'b0;
            odt_r <= 1'b0;
        end
        else if (ck_rise)
        begin
            cke_prev_r <= cke_s;
            if (pwr_state != d4f_pkg::PWR_SR)
            begin
                odt_r <= odt_s;
            end
            if (pwr_state == d4f_pkg::PWR_ON && cke_prev_r && !cke_s)
            begin
                if (!cs_s && act_s && enc == d4f_pkg::ENC_REF)
                begin
                    pwr_state <= d4f_pkg::PWR_SR;
                end
                else if (|bank_open)
                begin
                    pwr_state <= d4f_pkg::PWR_APD;
                end
                else
                begin
                    pwr_state <= d4f_pkg::PWR_PPD;
                end
            end
            else if (pwr_state != d4f_pkg::PWR_ON && cke_s)
            begin
                pwr_state <= d4f_pkg::PWR_ON;
            end
        end
    end

    assign cmd_buf_en = (pwr_state == d4f_pkg::PWR_ON);
    assign ck_buf_en = (pwr_state != d4f_pkg::PWR_SR);
    assign odt_buf_en = (pwr_state != d4f_pkg::PWR_SR);
    assign rtt_nom_on = odt_r && rtt_nom_en;

    // ----------------------------------------
    // Latency check
    // ----------------------------------------
    always_comb
    begin
        logic cl_ok;
        logic cwl_ok;
        logic [5:0] al;
        al = 6'h00;
        cl_ok = (cl_sel == 5'h09) || (cl_sel >= 5'h0b && cl_sel <= 5'h10)
                || (cl_sel >= 5'h12 && cl_sel <= 5'h18);
        cwl_ok = (cwl_sel >= 5'h09 && cwl_sel <= 5'h0c) || cwl_sel == 5'h0e
                 || cwl_sel == 5'h10 || cwl_sel == 5'h12 || cwl_sel == 5'h14;
        unique case (al_sel)
            d4f_pkg::AL_ZERO: al = 6'h00;
            d4f_pkg::AL_CL_M1: al = {1'b0, cl_sel} - 6'h01;
            d4f_pkg::AL_CL_M2: al = {1'b0, cl_sel} - 6'h02;
            default:
            begin
                al = 6'h00;
                cl_ok = 1'b0;
            end
        endcase
        lat_ok = cl_ok && cwl_ok;
        read_lat = {1'b0, cl_sel} + al;
        write_lat = {1'b0, cwl_sel} + al;
    end

    // ----------------------------------------
    // Write data capture
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            wr_left <= 4'h0;
            push_r <= 1'b0;
            push_data_r <= 16'h0000;
            push_be_r <= 2'h0;
        end
        else
        begin
            push_r <= 1'b0;
            if (ck_rise && !cs_s && cke_s && act_s && enc == d4f_pkg::ENC_WR
                && pwr_state == d4f_pkg::PWR_ON && !par_bad)
            begin
                wr_left <= addr_s[d4f_pkg::BC_BIT] ? d4f_pkg::BURST_FULL
                                                  : d4f_pkg::BURST_CHOP;
            end
            else if (dqs_edge && wr_left != 4'h0)
            begin
                wr_left <= wr_left - 4'h1;
                for (int l = 0; l < 2; l++)
                begin
                    // Mask wins if software sets both functions
                    push_be_r[l] <= mr5_dm_en ? dm_s[l] : 1'b1;
                    push_data_r[l*8 +: 8] <= (mr5_wdbi_en && !mr5_dm_en && !dm_s[l])
                                             ? ~dq_s[l*8 +: 8] : dq_s[l*8 +: 8];
                end
                push_r <= !mr5_dm_en || (|dm_s);
            end
        end
    end

    assign fq.in_valid = push_r;
    assign fq.in_data = {push_be_r, push_data_r};
    assign fq.out_ready = wr_ready;
    assign wr_valid = fq.out_valid;
    assign {wr_be, wr_data} = fq.out_data;
    // A full FIFO cannot stall the strobe, so the beat is lost and flagged
    assign wr_drop = push_r && !fq.in_ready;

    d4f_fifo #(.W(18), .DEPTH(d4f_pkg::FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .f(fq.fifo)
    );

    // ----------------------------------------
    // Read data drive with bus inversion
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            dq_o <= 16'h0000;
            dbi_n_o <= 2'h3;
            dq_oe_n <= 1'b1;
        end
        else
        begin
            dq_oe_n <= !rd_valid;
            if (rd_valid)
            begin
                for (int l = 0; l < 2; l++)
                begin
                    if (mr5_rdbi_en && ones_gt4(rd_data[l*8 +: 8]))
                    begin
                        dq_o[l*8 +: 8] <= ~rd_data[l*8 +: 8];
                        dbi_n_o[l] <= 1'b0;
                    end
                    else
                    begin
                        dq_o[l*8 +: 8] <= rd_data[l*8 +: 8];
                        dbi_n_o[l] <= 1'b1;
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // Alert
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            alert_cnt_r <= 8'h00;
        end
        else if (par_err)
        begin
            alert_cnt_r <= 8'(d4f_pkg::PAR_RECOV_CYC);
        end
        else if (crc_err && alert_cnt_r == 8'h00)
        begin
            alert_cnt_r <= 8'(d4f_pkg::CRC_PULSE_CYC);
        end
        else if (alert_cnt_r != 8'h00)
        begin
            alert_cnt_r <= alert_cnt_r - 8'h01;
        end
    end

    assign alert_n_o = 1'b0;
    assign alert_oe_n = (alert_cnt_r == 8'h00);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_cmd_on_edge: assert property (cmd_valid |-> $past(ck_rise && !cs_s))
        else $error("command without clock edge or with select high");
    a_sr_exit: assert property (pwr_state == d4f_pkg::PWR_SR && ck_rise && cke_s
        |=> pwr_state == d4f_pkg::PWR_ON)
        else $error("self-refresh exit missed");
    a_odt_ignored: assert property (!rtt_nom_en |-> !rtt_nom_on)
        else $error("termination on while disabled");
    a_act_row: assert property (cmd_valid && cmd == d4f_pkg::CMD_ACT
        |-> cmd_row[15:14] == $past({cas_s, we_s}))
        else $error("activate row bits wrong");
    a_chop_len: assert property (cmd_valid && cmd == d4f_pkg::CMD_WR
        |-> wr_left == (cmd_bc4 ? 4'h4 : 4'h8))
        else $error("burst length wrong");
    a_mask_drop: assert property (push_r |-> |push_be_r)
        else $error("fully masked beat stored");
    a_read_dbi: assert property (!dq_oe_n && !dbi_n_o[0]
        |-> dq_o[7:0] == ~$past(rd_data[7:0]))
        else $error("inverted read byte wrong");
    a_par_alert: assert property (par_err |=> !alert_oe_n [*8])
        else $error("parity alert not held");
    a_pre_all: assert property (cmd_valid && cmd == d4f_pkg::CMD_PRE && cmd_ap
        |=> bank_open == '0)
        else $error("precharge all left a bank open");
    a_lat_sum: assert property (lat_ok && al_sel == d4f_pkg::AL_CL_M1
        |-> read_lat == {cl_sel, 1'b0} - 6'h01)
        else $error("additive latency wrong");

    c_write: cover property (cmd_valid && cmd == d4f_pkg::CMD_WR);
    c_self_refresh: cover property (pwr_state == d4f_pkg::PWR_SR);
    c_active_pd: cover property (pwr_state == d4f_pkg::PWR_APD);
    c_drop: cover property (wr_drop);
endmodule : d4f_front

/* testbench/d4f_ctl_model.sv */
// Controller model driving link clock, clock enable and command pins
`timescale 1ns/10ps
module d4f_ctl_model (
    // Clock
    input wire logic clk,
    // {ck_t, ck_c, cke, cs_n, odt, par, act, ras, cas, we, bg, ba, addr}
    output logic [26:0] pins
);
    initial pins = 27'h2800000;
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    // One link frame; the link clock stands still between frames
    task automatic issue(input logic [31:0] r, input logic c_n, k, o, bad);
        logic [20:0] ca;
        ca = {r[31:28], r[26:24], r[13:0]};
        // Pins held across the whole rise, never changed mid-frame
        pins = {2'b01, k, c_n, o, ^ca ^ bad, ca};
        step(2);
        pins[26:25] = 2'b10;
        step(4);
        pins[26:25] = 2'b01;
        step(2);
    endtask : issue
endmodule : d4f_ctl_model

/* testbench/d4f_front_tb.sv */
// Self-checking bench for the command pin front end
`timescale 1ns/10ps
module d4f_front_tb;
    logic clk = 1'b0, resetn = 1'b0;
    logic ck_t, ck_c, cke, cs_n, odt, par, act_n, ras_n, cas_n_a15, we_n_a14, bg0;
    logic [1:0] ba, dqs_t = 2'h0, dm_dbi_n_i = 2'h3, al_sel = 2'h0, dbi_n_o, cmd_ba, wr_be;
    logic [13:0] addr;
    logic [26:0] pins;
    logic [15:0] dq_i = 16'h0, dq_o, rd_data = 16'h0, cmd_row, wr_data;
    logic dq_oe_n, alert_n_o, alert_oe_n, cmd_valid, cmd_bg, cmd_ap, cmd_bc4, par_err;
    logic ck_buf_en, cmd_buf_en, odt_buf_en, rtt_nom_on, lat_ok, wr_valid, wr_drop;
    logic rtt_nom_en = 1'b1, mr5_dm_en = 1'b0, mr5_wdbi_en = 1'b0, mr5_rdbi_en = 1'b1;
    logic par_en = 1'b1, crc_err = 1'b0, wr_ready = 1'b1, rd_valid = 1'b0;
    logic [4:0] cl_sel = 5'h9, cwl_sel = 5'h9;
    logic [9:0] cmd_col;
    logic [2:0] mrs_sel;
    logic [5:0] read_lat, write_lat;
    logic [7:0] bank_open;
    d4f_pkg::d4f_cmd_t cmd;
    d4f_pkg::d4f_pwr_t pwr_state;
    int errors = 0, check_count = 0, cyc = 0, n_cmd = 0, k;
    // Rows: op {act,ras,cas,we}, {bg,ba}, expected command, address
    logic [31:0] tbl [7] = '{32'h6660_1234, 32'hd140_0400, 32'hc230_1000, 32'ha020_0400,
                             32'h8700_0000, 32'he050_0400, 32'h9010_0000};
    assign {ck_t, ck_c, cke, cs_n, odt, par, act_n, ras_n, cas_n_a15, we_n_a14, bg0, ba,
            addr} = pins;
    d4f_ctl_model m (.clk(clk), .pins(pins));
    d4f_front u_dut (.*);
    initial forever #12.5 clk = ~clk;
    task automatic chk(input logic [31:0] got, exp, input string s);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, s, got, exp);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    // Pulse counter and hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cmd_valid === 1'b1)
            n_cmd++;
        if (cyc == 2000)
        begin
            errors++;
            final_report();
        end
    end
    initial
    begin
        m.step(10);
        resetn = 1'b1;
        // First edge after reset only primes the clock enable history
        m.issue(32'h0, 1'b1, 1'b1, 1'b0, 1'b0);
        for (int i = 0; i < 7; i++)
        begin
            k = n_cmd;
            m.issue(tbl[i], 1'b0, 1'b1, 1'b0, 1'b0);
            chk(n_cmd - k, 1, "count");
            chk(cmd, tbl[i][22:20], "cmd");
            chk({cmd_bg, cmd_ba}, tbl[i][26:24], "bank");
            chk(mrs_sel, tbl[i][26:24], "mrs");
            chk(cmd_col, tbl[i][9:0], "col");
            chk(cmd_ap, tbl[i][10], "ap");
            chk(cmd_bc4, !tbl[i][12], "bc4");
            if (i == 0)
                chk({bank_open, cmd_row}, {8'h40, tbl[0][29:28], tbl[0][13:0]}, "act");
        end
        chk(bank_open, 8'h0, "closed");
        $display("command table done");
        k = n_cmd;
        m.issue(tbl[0], 1'b1, 1'b1, 1'b0, 1'b0);
        chk(n_cmd - k, 0, "deselect");
        m.issue(tbl[0], 1'b0, 1'b1, 1'b0, 1'b1);
        chk(n_cmd - k, 0, "parity");
        chk(alert_oe_n, 1'b0, "alert");
        m.step(90);
        chk(alert_oe_n, 1'b1, "alert end");
        crc_err = 1'b1;
        m.step(1);
        crc_err = 1'b0;
        m.step(2);
        chk(alert_oe_n, 1'b0, "crc alert");
        m.step(12);
        chk(alert_oe_n, 1'b1, "crc end");
        $display("select and alert done");
        m.issue(tbl[0], 1'b0, 1'b1, 1'b1, 1'b0);
        chk(rtt_nom_on, 1'b1, "rtt");
        rtt_nom_en = 1'b0;
        m.step(1);
        chk(rtt_nom_on, 1'b0, "rtt off");
        m.issue(32'h0, 1'b1, 1'b0, 1'b0, 1'b0);
        chk(pwr_state, d4f_pkg::PWR_APD, "apd");
        chk({ck_buf_en, odt_buf_en, cmd_buf_en}, 3'b110, "pd bufs");
        m.issue(32'h0, 1'b1, 1'b1, 1'b0, 1'b0);
        chk(pwr_state, d4f_pkg::PWR_ON, "wake");
        m.issue(tbl[3], 1'b0, 1'b1, 1'b0, 1'b0);
        m.issue(tbl[6], 1'b0, 1'b0, 1'b0, 1'b0);
        chk(pwr_state, d4f_pkg::PWR_SR, "sr");
        chk(ck_buf_en, 1'b0, "sr bufs");
        m.issue(32'h0, 1'b1, 1'b1, 1'b0, 1'b0);
        chk(pwr_state, d4f_pkg::PWR_ON, "sr exit");
        $display("termination and power done");
        // Chopped write: kept, fully masked, then two inverted beats
        wr_ready = 1'b0;
        m.issue(32'hc000_0000, 1'b0, 1'b1, 1'b0, 1'b0);
        for (int b = 0; b < 4; b++)
        begin
            {mr5_dm_en, mr5_wdbi_en} = (b < 2) ? 2'b10 : 2'b01;
            dq_i = (b < 2) ? 16'h1234 : 16'h00ff;
            dm_dbi_n_i = (b == 0) ? 2'b01 : 2'b00;
            dqs_t = ~dqs_t;
            m.step(4);
        end
        chk({wr_valid, wr_be, wr_data}, {1'b1, 2'b01, 16'h1234}, "wr mask");
        wr_ready = 1'b1;
        m.step(1);
        wr_ready = 1'b0;
        chk({wr_valid, wr_be, wr_data}, {1'b1, 2'b11, 16'hff00}, "wr dbi");
        wr_ready = 1'b1;
        m.step(2);
        chk(wr_valid, 1'b0, "wr count");
        $display("write data done");
        al_sel = d4f_pkg::AL_CL_M1;
        m.step(1);
        chk({lat_ok, read_lat, write_lat}, {1'b1, 6'h11, 6'h11}, "al");
        cl_sel = 5'h0a;
        m.step(1);
        chk(lat_ok, 1'b0, "cl 10");
        $display("latency done");
        rd_data = 16'h00ff;
        rd_valid = 1'b1;
        m.step(1);
        rd_valid = 1'b0;
        chk({dq_oe_n, dbi_n_o, dq_o}, {3'b010, 16'h0000}, "rdbi");
        $display("read inversion done");
        resetn = 1'b0;
        m.step(2);
        chk({cmd_valid, pwr_state, dq_oe_n, dbi_n_o, alert_oe_n, bank_open, wr_valid},
            {1'b0, d4f_pkg::PWR_ON, 1'b1, 2'b11, 1'b1, 8'h00, 1'b0}, "reset");
        resetn = 1'b1;
        k = n_cmd;
        m.issue(tbl[0], 1'b0, 1'b1, 1'b0, 1'b0);
        chk(n_cmd - k, 0, "primer");
        m.issue(tbl[0], 1'b0, 1'b1, 1'b0, 1'b0);
        chk(n_cmd - k, 1, "after reset");
        $display("reset done");
        final_report();
    end
endmodule : d4f_front_tb
